// file: logic/emb_defs.svh
// Constants for the emulator port and break block
`ifndef EMB_DEFS_SVH
`define EMB_DEFS_SVH
`define EMB_D_W 6
`define EMB_GRP_W 4
`define EMB_IN_W 4
`define EMB_TIMER_W 8
`define EMB_TIMER_PRESCALE 4
`define EMB_GROUPS 3
`define EMB_IDX_D 0
`define EMB_IDX_ZERO 1
`define EMB_IDX_ONE 2
`define EMB_PORT_RST_D 6'h3F
`define EMB_PORT_RST_GRP 4'hF
`endif

// file: logic/emb_pkg.sv
// Types shared by the emulator port and break block
package emb_pkg;
  typedef enum logic [2:0] {
    EMB_OP_OTHER = 3'h0,
    EMB_OP_OUT = 3'h1,
    EMB_OP_IN = 3'h2,
    EMB_OP_WDOG_RESTART = 3'h3,
    EMB_OP_PWR_DOWN = 3'h4,
    EMB_OP_PWR_DOWN_ALT = 3'h5,
    EMB_OP_PWR_DOWN_ARM = 3'h6
  } emb_op_e;
  typedef enum logic [1:0] {
    EMB_SEL_D = 2'h0,
    EMB_SEL_ZERO = 2'h1,
    EMB_SEL_ONE = 2'h2,
    EMB_SEL_OTHER = 2'h3
  } emb_sel_e;
  typedef enum logic [2:0] {
    EMB_ST_RUN = 3'h1,
    EMB_ST_HALT = 3'h2,
    EMB_ST_BACKUP = 3'h4
  } emb_state_e;
  typedef enum logic [1:0] {
    EMB_CAUSE_NONE = 2'h0,
    EMB_CAUSE_HW = 2'h1,
    EMB_CAUSE_FORCE = 2'h2,
    EMB_CAUSE_TRIG = 2'h3
  } emb_cause_e;
endpackage

// file: logic/emb_brk_if.sv
// Signals between the port emulation top and the break unit
`timescale 1ns/1ps
interface emb_brk_if;
  logic boundary;
  logic cont_run;
  logic stopped;
  logic hw_hit;
  logic force_req;
  logic trig_in;
  logic trig_rising;
  logic trig_en;
  logic halt_take;
  emb_pkg::emb_cause_e cause;
  logic trace_hit;
  modport top (output boundary, output cont_run, output stopped, output hw_hit,
    output force_req, output trig_in, output trig_rising, output trig_en,
    input halt_take, input cause, input trace_hit);
  modport unit (input boundary, input cont_run, input stopped, input hw_hit,
    input force_req, input trig_in, input trig_rising, input trig_en,
    output halt_take, output cause, output trace_hit);
endinterface

// file: logic/emb_break_unit.sv
// Break decision: hardware, forced and external trigger breaks
`timescale 1ns/1ps
module emb_break_unit (
  input wire logic clk,
  input wire logic rst_n,
  emb_brk_if.unit b
);
  logic frc_s1, frc_s2, frc_s3, trg_s1, trg_s2, trg_s3;
  logic hw_pend, frc_pend, trg_pend, trace_q;
  logic next_hw_pend, next_frc_pend, next_trg_pend;
  logic frc_edge, trg_edge, take_any, take_hw, take;
  emb_pkg::emb_cause_e cause_c;

  always_comb begin
    // (RQ16) Host halt request resynchronised, acted on at a boundary
    frc_edge = frc_s2 & ~frc_s3;
    // (RQ15) Selected trigger edge feeds trace and break alike
    trg_edge = b.trig_rising ? (trg_s2 & ~trg_s3) : (~trg_s2 & trg_s3);
    // (RQ12) Forced and trigger breaks stop even inside a run
    take_any = b.boundary & ~b.stopped & (frc_pend | trg_pend);
    // (RQ11) Hardware hit waits for the run to end
    take_hw = b.boundary & ~b.stopped & hw_pend & ~b.cont_run;
    take = take_any | take_hw;
    if (frc_pend) begin
      cause_c = emb_pkg::EMB_CAUSE_FORCE;
    end else if (trg_pend) begin
      cause_c = emb_pkg::EMB_CAUSE_TRIG;
    end else if (hw_pend) begin
      cause_c = emb_pkg::EMB_CAUSE_HW;
    end else begin
      cause_c = emb_pkg::EMB_CAUSE_NONE;
    end
    // A new event in the taking cycle stays pending
    next_hw_pend = b.hw_hit | (hw_pend & ~take);
    next_frc_pend = frc_edge | (frc_pend & ~take);
    next_trg_pend = (trg_edge & b.trig_en) | (trg_pend & ~take);
  end

  assign b.halt_take = take;
  assign b.cause = cause_c;
  assign b.trace_hit = trace_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frc_s1 <= 1'b0;
      frc_s2 <= 1'b0;
      frc_s3 <= 1'b0;
      trg_s1 <= 1'b0;
      trg_s2 <= 1'b0;
      trg_s3 <= 1'b0;
      hw_pend <= 1'b0;
      frc_pend <= 1'b0;
      trg_pend <= 1'b0;
      trace_q <= 1'b0;
    end else begin
      frc_s1 <= b.force_req;
      frc_s2 <= frc_s1;
      frc_s3 <= frc_s2;
      trg_s1 <= b.trig_in;
      trg_s2 <= trg_s1;
      trg_s3 <= trg_s2;
      hw_pend <= next_hw_pend;
      frc_pend <= next_frc_pend;
      trg_pend <= next_trg_pend;
      trace_q <= trg_edge;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_hw_outside_run;
    take && (cause_c == emb_pkg::EMB_CAUSE_HW) |-> !b.cont_run;
  endproperty
  a_hw_outside_run: assert property (p_hw_outside_run) // RQ11
    else $error("hardware break taken inside a continuous run");

  property p_force_in_run;
    b.boundary && !b.stopped && frc_pend |-> take && (cause_c == emb_pkg::EMB_CAUSE_FORCE);
  endproperty
  a_force_in_run: assert property (p_force_in_run) // RQ12
    else $error("pending forced break not taken at boundary");

  property p_trace_edge;
    trg_edge |=> b.trace_hit ##1 !b.trace_hit;
  endproperty
  a_trace_edge: assert property (p_trace_edge) // RQ15
    else $error("trace pulse missing for selected trigger edge");

  property p_force_latch;
    $rose(frc_s2) |=> frc_pend;
  endproperty
  a_force_latch: assert property (p_force_latch) // RQ16
    else $error("forced break request not latched");

  c_force_run: cover property (take && b.cont_run);
  c_trig_break: cover property (take && cause_c == emb_pkg::EMB_CAUSE_TRIG);
endmodule

// file: logic/emb_port_emu.sv
// Emulator port timing, backup mode, check point, timer and break control
// Operation
// (RQ1) Clock and timers keep running while halted
// (RQ2) No working watchdog timer is provided
// (RQ3) Check point pulses during watchdog restart cycles
// (RQ4) Emulated groups update at next output T2
// (RQ5) Other ports update at own T3
// (RQ6) Inputs sampled as on the real part
// (RQ7) Backup mode drives emulated outputs high
// (RQ8) Leaving backup restores previous emulated outputs
// (RQ9) Either power-down instruction alone enters backup
// (RQ10) Power-down arming instruction does nothing
// (RQ11) Hardware breaks wait until run ends
// (RQ12) Forced and trigger breaks stop inside runs
// (RQ13) Debugger resumes after end of run
// (RQ14) Run breakpoint halts before first following instruction
// (RQ15) Trigger edge selectable, shared by trace and break
// (RQ16) Forced break halts at next boundary
`timescale 1ns/1ps
`include "emb_defs.svh"
module emb_port_emu #(
  parameter int D_W = `EMB_D_W,
  parameter int GRP_W = `EMB_GRP_W,
  parameter int IN_W = `EMB_IN_W,
  parameter int TMR_W = `EMB_TIMER_W,
  parameter int PRESCALE = `EMB_TIMER_PRESCALE
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic t2_start,
  input wire logic t3_start,
  input wire logic instr_end,
  input wire emb_pkg::emb_op_e instr_op,
  input wire emb_pkg::emb_sel_e out_sel,
  input wire logic [D_W-1:0] out_data,
  input wire logic [IN_W-1:0] port_in,
  input wire logic wake_req,
  input wire logic resume_req,
  input wire logic hw_bp_hit,
  input wire logic cont_run,
  input wire logic force_break_req,
  input wire logic trig_in,
  input wire logic trig_rising,
  input wire logic trig_break_en,
  output logic [D_W-1:0] d_port_out,
  output logic [GRP_W-1:0] grp_zero_out,
  output logic [GRP_W-1:0] grp_one_out,
  output logic [GRP_W-1:0] other_port_out,
  output logic [IN_W-1:0] port_in_latched,
  output logic check_test_point,
  output logic [TMR_W-1:0] timer_value,
  output logic halted,
  output logic in_backup,
  output emb_pkg::emb_cause_e break_cause,
  output logic trace_hit
);
  localparam int NG = `EMB_GROUPS;
  localparam int PS_W = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;

  function automatic int grp_idx(emb_pkg::emb_sel_e s);
    if (s == emb_pkg::EMB_SEL_ZERO) begin
      return `EMB_IDX_ZERO;
    end else if (s == emb_pkg::EMB_SEL_ONE) begin
      return `EMB_IDX_ONE;
    end else begin
      return `EMB_IDX_D;
    end
  endfunction

  emb_pkg::emb_state_e state, next_state;
  emb_pkg::emb_cause_e next_break_cause;
  logic [D_W-1:0] emu_val [NG];
  logic [D_W-1:0] emu_pend [NG];
  logic [D_W-1:0] next_emu_val [NG];
  logic [D_W-1:0] next_emu_pend [NG];
  logic [NG-1:0] pend_v, next_pend_v;
  logic [D_W-1:0] next_d_port_out;
  logic [GRP_W-1:0] next_grp_zero_out, next_grp_one_out, next_other_port_out;
  logic [IN_W-1:0] next_port_in_latched;
  logic next_check_test_point, next_halted, next_in_backup;
  logic [PS_W-1:0] ps_cnt, next_ps_cnt;
  logic [TMR_W-1:0] next_timer_value;
  logic running, out_instr, tick;

  emb_brk_if brk ();
  assign brk.boundary = instr_end;
  assign brk.cont_run = cont_run;
  assign brk.stopped = ~running;
  assign brk.hw_hit = hw_bp_hit;
  assign brk.force_req = force_break_req;
  assign brk.trig_in = trig_in;
  assign brk.trig_rising = trig_rising;
  assign brk.trig_en = trig_break_en;
  assign trace_hit = brk.trace_hit;

  emb_break_unit emb_break_unit_inst (
    .clk(clk),
    .rst_n(rst_n),
    .b(brk.unit)
  );

  assign running = (state == emb_pkg::EMB_ST_RUN);
  assign out_instr = running && (instr_op == emb_pkg::EMB_OP_OUT);
  assign tick = (ps_cnt == PS_W'(PRESCALE - 1));

  // Run, halt and backup sequencing
  always_comb begin
    next_state = state;
    next_break_cause = break_cause;
    case (state)
      emb_pkg::EMB_ST_RUN: begin
        // (RQ14) Halt lands on the boundary the break unit picks
        if (brk.halt_take) begin
          next_state = emb_pkg::EMB_ST_HALT;
          next_break_cause = brk.cause;
        // (RQ9) Power-down alone enters backup; (RQ10) arming ignored
        end else if (t3_start && (instr_op == emb_pkg::EMB_OP_PWR_DOWN ||
                                  instr_op == emb_pkg::EMB_OP_PWR_DOWN_ALT)) begin
          next_state = emb_pkg::EMB_ST_BACKUP;
        end
      end
      // (RQ13) Halt holds until the host raises resume_req
      emb_pkg::EMB_ST_HALT: begin
        if (resume_req) begin
          next_state = emb_pkg::EMB_ST_RUN;
        end
      end
      emb_pkg::EMB_ST_BACKUP: begin
        if (wake_req) begin
          next_state = emb_pkg::EMB_ST_RUN;
        end
      end
      default: begin
        next_state = emb_pkg::EMB_ST_RUN;
      end
    endcase
    next_halted = (next_state == emb_pkg::EMB_ST_HALT);
    next_in_backup = (next_state == emb_pkg::EMB_ST_BACKUP);
    // (RQ3) Check point follows watchdog restart cycles
    next_check_test_point = running && (instr_op == emb_pkg::EMB_OP_WDOG_RESTART);
  end

  // Port outputs and input sampling
  always_comb begin
    next_emu_val = emu_val;
    next_emu_pend = emu_pend;
    next_pend_v = pend_v;
    next_other_port_out = other_port_out;
    next_port_in_latched = port_in_latched;
    // (RQ4) Held value goes out at T2 of the next output
    if (out_instr && t2_start) begin
      for (int g = 0; g < NG; g++) begin
        if (pend_v[g]) begin
          next_emu_val[g] = emu_pend[g];
          next_pend_v[g] = 1'b0;
        end
      end
    end
    if (out_instr && t3_start) begin
      if (out_sel != emb_pkg::EMB_SEL_OTHER) begin
        next_emu_pend[grp_idx(out_sel)] = out_data;
        next_pend_v[grp_idx(out_sel)] = 1'b1;
      // (RQ5) Plain ports change at their own T3
      end else begin
        next_other_port_out = out_data[GRP_W-1:0];
      end
    end
    // (RQ6) Inputs latched at T3 of an input instruction
    if (running && instr_op == emb_pkg::EMB_OP_IN && t3_start) begin
      next_port_in_latched = port_in;
    end
    // (RQ7) Backup forces emulated pins high; (RQ8) held values return after
    if (next_state == emb_pkg::EMB_ST_BACKUP) begin
      next_d_port_out = '1;
      next_grp_zero_out = '1;
      next_grp_one_out = '1;
    end else begin
      next_d_port_out = next_emu_val[`EMB_IDX_D];
      next_grp_zero_out = next_emu_val[`EMB_IDX_ZERO][GRP_W-1:0];
      next_grp_one_out = next_emu_val[`EMB_IDX_ONE][GRP_W-1:0];
    end
  end

  // (RQ1) Timer counts once every PRESCALE cycles regardless of halt; (RQ2) no watchdog here
  always_comb begin
    next_ps_cnt = tick ? '0 : ps_cnt + PS_W'(1);
    next_timer_value = tick ? timer_value + TMR_W'(1) : timer_value;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= emb_pkg::EMB_ST_RUN;
      break_cause <= emb_pkg::EMB_CAUSE_NONE;
      for (int g = 0; g < NG; g++) begin
        emu_val[g] <= `EMB_PORT_RST_D;
        emu_pend[g] <= `EMB_PORT_RST_D;
      end
      pend_v <= '0;
      d_port_out <= `EMB_PORT_RST_D;
      grp_zero_out <= `EMB_PORT_RST_GRP;
      grp_one_out <= `EMB_PORT_RST_GRP;
      other_port_out <= `EMB_PORT_RST_GRP;
      port_in_latched <= '0;
      check_test_point <= 1'b0;
      halted <= 1'b0;
      in_backup <= 1'b0;
      ps_cnt <= '0;
      timer_value <= '0;
    end else begin
      state <= next_state;
      break_cause <= next_break_cause;
      emu_val <= next_emu_val;
      emu_pend <= next_emu_pend;
      pend_v <= next_pend_v;
      d_port_out <= next_d_port_out;
      grp_zero_out <= next_grp_zero_out;
      grp_one_out <= next_grp_one_out;
      other_port_out <= next_other_port_out;
      port_in_latched <= next_port_in_latched;
      check_test_point <= next_check_test_point;
      halted <= next_halted;
      in_backup <= next_in_backup;
      ps_cnt <= next_ps_cnt;
      timer_value <= next_timer_value;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_timer_runs;
    tick |=> timer_value == $past(timer_value) + TMR_W'(1);
  endproperty
  a_timer_runs: assert property (p_timer_runs) // RQ1
    else $error("timer stalled");

  property p_ctp;
    running && instr_op == emb_pkg::EMB_OP_WDOG_RESTART |=> check_test_point;
  endproperty
  a_ctp: assert property (p_ctp) // RQ3
    else $error("check point missing in restart cycle");

  property p_emu_t3_hold;
    out_instr && t3_start && out_sel == emb_pkg::EMB_SEL_ZERO && !brk.halt_take
      |=> grp_zero_out == $past(grp_zero_out);
  endproperty
  a_emu_t3_hold: assert property (p_emu_t3_hold) // RQ4
    else $error("emulated group changed at issuing T3");

  property p_emu_t2;
    out_instr && t2_start && pend_v[`EMB_IDX_ONE] && !brk.halt_take
      |=> grp_one_out == $past(emu_pend[`EMB_IDX_ONE][GRP_W-1:0]);
  endproperty
  a_emu_t2: assert property (p_emu_t2) // RQ4
    else $error("emulated group not applied at next T2");

  property p_other_t3;
    out_instr && t3_start && out_sel == emb_pkg::EMB_SEL_OTHER
      |=> other_port_out == $past(out_data[GRP_W-1:0]);
  endproperty
  a_other_t3: assert property (p_other_t3) // RQ5
    else $error("plain port not updated at T3");

  property p_in_sample;
    running && instr_op == emb_pkg::EMB_OP_IN && t3_start |=> port_in_latched == $past(port_in);
  endproperty
  a_in_sample: assert property (p_in_sample) // RQ6
    else $error("input not sampled");

  property p_backup_high;
    in_backup |-> (&d_port_out) && (&grp_zero_out) && (&grp_one_out);
  endproperty
  a_backup_high: assert property (p_backup_high) // RQ7
    else $error("emulated output low in backup");

  property p_restore;
    in_backup && wake_req |=> !in_backup && d_port_out == $past(emu_val[`EMB_IDX_D]);
  endproperty
  a_restore: assert property (p_restore) // RQ8
    else $error("outputs not restored after backup");

  property p_pwr_down_enter;
    running && t3_start && !brk.halt_take &&
      (instr_op == emb_pkg::EMB_OP_PWR_DOWN || instr_op == emb_pkg::EMB_OP_PWR_DOWN_ALT)
      |=> in_backup;
  endproperty
  a_pwr_down_enter: assert property (p_pwr_down_enter) // RQ9
    else $error("power-down did not enter backup");

  property p_arm_none;
    running && instr_op == emb_pkg::EMB_OP_PWR_DOWN_ARM && !brk.halt_take
      |=> !in_backup && !halted;
  endproperty
  a_arm_none: assert property (p_arm_none) // RQ10
    else $error("arming instruction changed state");

  c_backup_cycle: cover property (in_backup ##1 !in_backup);
  c_halt_resume: cover property (halted ##[1:20] !halted);
  c_emu_update: cover property (out_instr && t2_start && pend_v != '0);
endmodule

// file: tb/emb_target_model.sv
// Target system stand-in: input pins and external trigger line
`timescale 1ns/1ps
module emb_target_model (
  input wire logic clk,
  output logic [3:0] pins,
  output logic trig
);
  initial begin
    pins = 4'h0;
    trig = 1'b0;
  end
  task automatic set_pins(input logic [3:0] v);
    @(negedge clk);
    pins = v;
  endtask
  // Held four cycles so the synchroniser sees both edges
  task automatic pulse_trig();
    @(negedge clk);
    trig = 1'b1;
    repeat (4) @(negedge clk);
    trig = 1'b0;
    repeat (4) @(negedge clk);
  endtask
endmodule

// file: tb/emb_port_emu_test.sv
// Self-checking bench for the emulator port and break block
`timescale 1ns/1ps
module emb_port_emu_test;
  logic clk = 1'b0, rst_n = 1'b0, t2_start = 1'b0, t3_start = 1'b0, instr_end = 1'b0;
  emb_pkg::emb_op_e instr_op = emb_pkg::EMB_OP_OTHER;
  emb_pkg::emb_sel_e out_sel = emb_pkg::EMB_SEL_OTHER;
  logic [5:0] out_data = 6'h00, d_port_out;
  logic [3:0] port_in, grp_zero_out, grp_one_out, other_port_out, port_in_latched;
  logic wake_req = 1'b0, resume_req = 1'b0, hw_bp_hit = 1'b0, cont_run = 1'b0;
  logic force_break_req = 1'b0, trig_in, trig_rising = 1'b1, trig_break_en = 1'b0;
  logic check_test_point, halted, in_backup, trace_hit;
  logic [7:0] timer_value, t0;
  emb_pkg::emb_cause_e break_cause;
  int errors = 0, n_compared = 0, n_ctp = 0, n_trace = 0;
  always #50 clk = ~clk;
  // Counted at the rising edge so the reads at the falling edge never race
  always @(posedge clk) begin
    if (check_test_point === 1'b1) n_ctp++;
    if (trace_hit === 1'b1) n_trace++;
  end
  emb_target_model emb_target_model_inst (.clk(clk), .pins(port_in), .trig(trig_in));
  emb_port_emu emb_port_emu_inst (.clk(clk), .rst_n(rst_n), .t2_start(t2_start),
    .t3_start(t3_start), .instr_end(instr_end), .instr_op(instr_op), .out_sel(out_sel),
    .out_data(out_data), .port_in(port_in), .wake_req(wake_req), .resume_req(resume_req),
    .hw_bp_hit(hw_bp_hit), .cont_run(cont_run), .force_break_req(force_break_req),
    .trig_in(trig_in), .trig_rising(trig_rising), .trig_break_en(trig_break_en),
    .d_port_out(d_port_out), .grp_zero_out(grp_zero_out), .grp_one_out(grp_one_out),
    .other_port_out(other_port_out), .port_in_latched(port_in_latched),
    .check_test_point(check_test_point), .timer_value(timer_value), .halted(halted),
    .in_backup(in_backup), .break_cause(break_cause), .trace_hit(trace_hit));
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // One instruction: T2 cycle, T3 cycle, boundary cycle
  task automatic instr(input emb_pkg::emb_op_e op, input emb_pkg::emb_sel_e sel,
    input logic [5:0] data, input logic cont);
    @(negedge clk);
    instr_op = op;
    out_sel = sel;
    out_data = data;
    t2_start = 1'b1;
    @(negedge clk);
    t2_start = 1'b0;
    t3_start = 1'b1;
    @(negedge clk);
    t3_start = 1'b0;
    instr_end = 1'b1;
    cont_run = cont;
    @(negedge clk);
    instr_end = 1'b0;
    cont_run = 1'b0;
    instr_op = emb_pkg::EMB_OP_OTHER;
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic chk_pins(input logic [5:0] d, input logic [3:0] z, input logic [3:0] o);
    chk({2'h0, d_port_out}, {2'h0, d});
    chk({4'h0, grp_zero_out}, {4'h0, z});
    chk({4'h0, grp_one_out}, {4'h0, o});
  endtask
  task automatic chk_halt(input logic h, input emb_pkg::emb_cause_e c);
    chk({7'h00, halted}, {7'h00, h});
    chk({6'h00, break_cause}, {6'h00, c});
  endtask
  task automatic t_reset();
    chk_pins(6'h3F, 4'hF, 4'hF);
    chk({4'h0, other_port_out}, 8'h0F);
    chk_halt(1'b0, emb_pkg::EMB_CAUSE_NONE);
  endtask
  task automatic t_ports();
    instr(emb_pkg::EMB_OP_OUT, emb_pkg::EMB_SEL_ZERO, 6'h05, 1'b0);
    chk_pins(6'h3F, 4'hF, 4'hF);
    instr(emb_pkg::EMB_OP_OUT, emb_pkg::EMB_SEL_OTHER, 6'h0A, 1'b0);
    chk({4'h0, other_port_out}, 8'h0A);
    chk_pins(6'h3F, 4'h5, 4'hF);
    instr(emb_pkg::EMB_OP_OUT, emb_pkg::EMB_SEL_D, 6'h2A, 1'b0);
    instr(emb_pkg::EMB_OP_OUT, emb_pkg::EMB_SEL_ONE, 6'h06, 1'b0);
    chk_pins(6'h2A, 4'h5, 4'hF);
    instr(emb_pkg::EMB_OP_OUT, emb_pkg::EMB_SEL_OTHER, 6'h03, 1'b0);
    chk_pins(6'h2A, 4'h5, 4'h6);
  endtask
  task automatic t_input();
    emb_target_model_inst.set_pins(4'h9);
    instr(emb_pkg::EMB_OP_IN, emb_pkg::EMB_SEL_OTHER, 6'h00, 1'b0);
    chk({4'h0, port_in_latched}, 8'h09);
    emb_target_model_inst.set_pins(4'h6);
    instr(emb_pkg::EMB_OP_OTHER, emb_pkg::EMB_SEL_OTHER, 6'h00, 1'b0);
    chk({4'h0, port_in_latched}, 8'h09);
  endtask
  task automatic t_check_point();
    n_ctp = 0;
    instr(emb_pkg::EMB_OP_WDOG_RESTART, emb_pkg::EMB_SEL_OTHER, 6'h00, 1'b0);
    @(negedge clk);
    // No watchdog exists; only the restart cycles are visible
    chk(n_ctp[7:0], 8'h03);
  endtask
  task automatic t_backup(input emb_pkg::emb_op_e op);
    instr(emb_pkg::EMB_OP_PWR_DOWN_ARM, emb_pkg::EMB_SEL_OTHER, 6'h00, 1'b0);
    chk({7'h00, in_backup}, 8'h00);
    chk_pins(6'h2A, 4'h5, 4'h6);
    instr(op, emb_pkg::EMB_SEL_OTHER, 6'h00, 1'b0);
    chk({7'h00, in_backup}, 8'h01);
    chk_pins(6'h3F, 4'hF, 4'hF);
    pulse(wake_req);
    chk({7'h00, in_backup}, 8'h00);
    chk_pins(6'h2A, 4'h5, 4'h6);
  endtask
  task automatic t_hw_break();
    pulse(hw_bp_hit);
    instr(emb_pkg::EMB_OP_OTHER, emb_pkg::EMB_SEL_OTHER, 6'h00, 1'b1);
    chk_halt(1'b0, emb_pkg::EMB_CAUSE_NONE);
    instr(emb_pkg::EMB_OP_OTHER, emb_pkg::EMB_SEL_OTHER, 6'h00, 1'b0);
    chk_halt(1'b1, emb_pkg::EMB_CAUSE_HW);
    t0 = timer_value;
    repeat (8) @(negedge clk);
    chk(timer_value, t0 + 8'h02);
    instr(emb_pkg::EMB_OP_OUT, emb_pkg::EMB_SEL_OTHER, 6'h0C, 1'b0);
    chk({4'h0, other_port_out}, 8'h03);
    pulse(resume_req);
    chk({7'h00, halted}, 8'h00);
  endtask
  task automatic t_force();
    @(negedge clk);
    force_break_req = 1'b1;
    repeat (4) @(negedge clk);
    instr(emb_pkg::EMB_OP_OTHER, emb_pkg::EMB_SEL_OTHER, 6'h00, 1'b1);
    chk_halt(1'b1, emb_pkg::EMB_CAUSE_FORCE);
    force_break_req = 1'b0;
    pulse(resume_req);
  endtask
  task automatic t_trigger();
    n_trace = 0;
    emb_target_model_inst.pulse_trig();
    chk(n_trace[7:0], 8'h01);
    chk({7'h00, halted}, 8'h00);
    trig_rising = 1'b0;
    trig_break_en = 1'b1;
    emb_target_model_inst.pulse_trig();
    instr(emb_pkg::EMB_OP_OTHER, emb_pkg::EMB_SEL_OTHER, 6'h00, 1'b1);
    chk_halt(1'b1, emb_pkg::EMB_CAUSE_TRIG);
    chk(n_trace[7:0], 8'h02);
    pulse(resume_req);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_ports();
    t_input();
    t_check_point();
    t_backup(emb_pkg::EMB_OP_PWR_DOWN);
    t_backup(emb_pkg::EMB_OP_PWR_DOWN_ALT);
    t_hw_break();
    t_force();
    t_trigger();
    wrap_up();
  end
  // Whole sequence takes well under 600 cycles
  initial begin
    #300000;
    errors++;
    wrap_up();
  end
endmodule
